// ### design/pll_clk_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock controller.
// Assumes a 12-bit APB byte address and a 100 MHz clk_sys.
`ifndef PLL_CLK_CFG_SVH
`define PLL_CLK_CFG_SVH
// Register byte offsets
`define OFF_CTL 12'h100
`define OFF_MULT 12'h110
`define OFF_PRE 12'h114
`define OFF_DIV1 12'h118
`define OFF_CMD 12'h138
`define OFF_STAT 12'h13c
`define OFF_ALIGN 12'h140
`define OFF_CHG 12'h144
`define OFF_DIV4 12'h160
// Field positions
`define CTL_MODE 0
`define CTL_RST 3
`define CTL_SRC 5
`define CTL_ONE 6
`define DIV_EN 15
`define CMD_GO 0
`define STAT_BUSY 0
`define STAT_LOCK 1
// Reset values
`define RST_CTL_SRC 1'b1
`define RST_CTL_RST 1'b1
`define RST_DIV_EN 1'b1
// Timing: clock period and PLL lock time
`define CLK_NS 10
`define LOCK_NS 2000
`define LOCK_CYC ((`LOCK_NS + `CLK_NS - 1) / `CLK_NS)
`define REF_HALF_CYC 64
`endif

// ### design/pll_clk_pkg.sv
// Types shared by the clock controller.
// Assumes pll_clk_cfg.svh holds the numbers.
package pll_clk_pkg;
    // Ratio-apply sequencer states
    typedef enum logic [1:0] {GO_IDLE, GO_PAUSE, GO_DONE} go_state_type;
    typedef logic [4:0] ratio_type;
endpackage

// ### design/pll_clock_divider_controller.sv
// PLL clock controller: mode select, pre-divider, PLL model, system dividers, APB registers.
// Assumes clk_sys is the fast oscillator; the reference clock and the PLL output are
// modelled as half-period tick enables, and every output clock is a flop level.
`include "pll_clk_cfg.svh"

module pll_clock_divider_controller
    import pll_clk_pkg::*;
#(
    parameter int NUM_DIV = 16,
    parameter int REF_HALF = `REF_HALF_CYC,
    parameter int LOCK_CYC = `LOCK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Generated clocks
    output logic aux_ref_clock,
    output logic [NUM_DIV-1:0] system_clock
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic ctl_mode;
        logic ctl_rst;
        logic ctl_src;
        logic [5:0] mult;
        ratio_type pre_ratio;
        logic pre_en;
        logic [NUM_DIV-1:0][4:0] div_ratio;
        logic [NUM_DIV-1:0][4:0] act_ratio;
        logic [NUM_DIV-1:0] div_en;
        logic [NUM_DIV-1:0] align;
        logic [NUM_DIV-1:0] chg;
        logic [NUM_DIV-1:0] hold;
        logic [NUM_DIV-1:0] op_mask;
        logic [NUM_DIV-1:0][4:0] cnt;
        logic [NUM_DIV-1:0] clk_out;
        go_state_type go;
        logic [7:0] ref_cnt;
        logic ref_lvl;
        logic [11:0] nco;
        logic [15:0] lock_cnt;
        logic locked;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } state_type;

    localparam state_type RESET_STATE = '{
        ctl_src: `RST_CTL_SRC,
        ctl_rst: `RST_CTL_RST,
        div_en: {NUM_DIV{`RST_DIV_EN}},
        go: GO_IDLE,
        default: '0
    };

    state_type q;
    state_type next_q;
    logic wr;
    logic hit;
    logic ref_tick;
    logic nco_tick;
    logic src_tick;
    logic pll_mode;
    logic go_req;
    logic [31:0] rd;
    logic [11:0] thr;
    logic [12:0] sum;
    logic [NUM_DIV-1:0] set_chg;
    logic [NUM_DIV-1:0] rel;

    // Byte address of system divider i: two separate banks
    function automatic logic [11:0] div_addr(input int i);
        return (i < 3) ? 12'(`OFF_DIV1 + 4 * i) : 12'(`OFF_DIV4 + 4 * (i - 3));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_q = q;
        wr = psel & penable & q.pready & pwrite;
        hit = 1'b0;
        rd = 32'h0;
        go_req = 1'b0;
        set_chg = '0;
        rel = '0;
        nco_tick = 1'b0;
        // Reference clock model and auxiliary copy
        ref_tick = (q.ref_cnt == 8'(REF_HALF - 1));
        next_q.ref_cnt = ref_tick ? 8'h00 : q.ref_cnt + 8'h01;
        if (ref_tick) begin
            next_q.ref_lvl = ~q.ref_lvl;
        end
        // Register decode; writes land only at the edge where pready is seen high
        case (paddr)
            `OFF_CTL: begin
                hit = 1'b1;
                rd[`CTL_ONE] = 1'b1;
                rd[`CTL_SRC] = q.ctl_src;
                rd[`CTL_RST] = q.ctl_rst;
                rd[`CTL_MODE] = q.ctl_mode;
                if (wr) begin
                    next_q.ctl_src = pwdata[`CTL_SRC];
                    next_q.ctl_rst = pwdata[`CTL_RST];
                    next_q.ctl_mode = pwdata[`CTL_MODE];
                end
            end
            `OFF_MULT: begin
                hit = 1'b1;
                rd[5:0] = q.mult;
                if (wr) begin
                    next_q.mult = pwdata[5:0];
                end
            end
            `OFF_PRE: begin
                hit = 1'b1;
                rd[`DIV_EN] = q.pre_en;
                rd[4:0] = q.pre_ratio;
                if (wr) begin
                    next_q.pre_en = pwdata[`DIV_EN];
                    next_q.pre_ratio = pwdata[4:0];
                end
            end
            `OFF_CMD: begin
                hit = 1'b1;
                go_req = wr & pwdata[`CMD_GO];
            end
            `OFF_STAT: begin
                hit = 1'b1;
                rd[`STAT_BUSY] = (q.go != GO_IDLE);
                rd[`STAT_LOCK] = q.locked;
            end
            `OFF_ALIGN: begin
                hit = 1'b1;
                rd[NUM_DIV-1:0] = q.align;
                if (wr) begin
                    next_q.align = pwdata[NUM_DIV-1:0];
                end
            end
            `OFF_CHG: begin
                hit = 1'b1;
                rd[NUM_DIV-1:0] = q.chg;
            end
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < NUM_DIV; i++) begin
            if (paddr == div_addr(i)) begin
                hit = 1'b1;
                rd[`DIV_EN] = q.div_en[i];
                rd[4:0] = q.div_ratio[i];
                if (wr) begin
                    next_q.div_en[i] = pwdata[`DIV_EN];
                    next_q.div_ratio[i] = pwdata[4:0];
                    set_chg[i] = (pwdata[4:0] != q.div_ratio[i]);
                end
            end
        end

        // One wait state: pready, read data and error all come from flops
        next_q.pready = psel & penable & ~q.pready;
        next_q.prdata = next_q.pready ? rd : 32'h0;
        next_q.pslverr = next_q.pready & ~hit;
        // Mode select counts only once its source bit is cleared
        pll_mode = ~q.ctl_src & q.ctl_mode;
        // Pre-divider and PLL as a phase accumulator: out rate = ref * (m+1) / (p+1)
        thr = 12'(({7'h00, q.pre_ratio} + 12'h001) * 12'(REF_HALF));
        sum = {1'b0, q.nco} + {7'h00, q.mult} + 13'h0001;
        if (q.ctl_rst || !q.pre_en) begin
            next_q.nco = 12'h000;
        end else if (sum >= {1'b0, thr}) begin
            next_q.nco = 12'(sum - {1'b0, thr});
            nco_tick = 1'b1;
        end else begin
            next_q.nco = sum[11:0];
        end
        // Lock timer restarts on every PLL reset
        if (q.ctl_rst) begin
            next_q.lock_cnt = 16'h0000;
            next_q.locked = 1'b0;
        end else if (!q.locked) begin
            next_q.lock_cnt = q.lock_cnt + 16'h0001;
            next_q.locked = (q.lock_cnt == 16'(LOCK_CYC - 1));
        end
        // Divider input: locked PLL output, or the reference in bypass
        src_tick = pll_mode ? (nco_tick & q.locked) : ref_tick;
        // Ratio-apply sequencer
        unique case (q.go)
            GO_IDLE: begin
                if (go_req) begin
                    next_q.op_mask = q.chg;
                    next_q.hold = q.chg & q.align;
                    for (int i = 0; i < NUM_DIV; i++) begin
                        if (q.chg[i] && !q.align[i]) begin
                            next_q.act_ratio[i] = q.div_ratio[i];
                        end
                    end
                    next_q.go = ((q.chg & q.align) != '0) ? GO_PAUSE : GO_DONE;
                end
            end
            GO_PAUSE: begin
                // Restart only once every held clock sits low
                if (src_tick && (q.hold & q.clk_out) == '0) begin
                    rel = q.hold;
                    for (int i = 0; i < NUM_DIV; i++) begin
                        if (q.hold[i]) begin
                            next_q.act_ratio[i] = q.div_ratio[i];
                        end
                    end
                    next_q.hold = '0;
                    next_q.go = GO_DONE;
                end
            end
            GO_DONE: begin
                next_q.chg = q.chg & ~q.op_mask;
                next_q.go = GO_IDLE;
            end
        endcase
        // A flag set in the clearing cycle survives
        next_q.chg = next_q.chg | set_chg;
        // System dividers count half periods, so odd ratios keep 50% duty
        for (int i = 0; i < NUM_DIV; i++) begin
            if (!next_q.div_en[i]) begin
                next_q.clk_out[i] = 1'b0;
                next_q.cnt[i] = 5'h00;
            end else if (rel[i]) begin
                next_q.clk_out[i] = 1'b1;
                next_q.cnt[i] = 5'h00;
            end else if (q.hold[i] && !q.clk_out[i]) begin
                next_q.cnt[i] = 5'h00;
            end else if (src_tick) begin
                if (q.cnt[i] >= q.act_ratio[i]) begin
                    next_q.clk_out[i] = ~q.clk_out[i];
                    next_q.cnt[i] = 5'h00;
                end else begin
                    next_q.cnt[i] = q.cnt[i] + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign aux_ref_clock = q.ref_lvl;
    assign system_clock = q.clk_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_disabled_quiet;
        (system_clock & ~q.div_en) == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled divider drives a clock");
    property p_src_ignored;
        q.ctl_src && ref_tick |-> src_tick;
    endproperty
    a_src_ignored: assert property (p_src_ignored)
        else $error("mode bit acted while its source bit was set");
    property p_aux_follows;
        ref_tick |=> (aux_ref_clock != $past(aux_ref_clock));
    endproperty
    a_aux_follows: assert property (p_aux_follows)
        else $error("auxiliary clock missed a reference edge");
    property p_ratio_deferred;
        wr && q.go == GO_IDLE && !go_req |=> q.act_ratio == $past(q.act_ratio);
    endproperty
    a_ratio_deferred: assert property (p_ratio_deferred)
        else $error("running ratio changed without apply");
    // Busy bit read back must mirror the sequencer in the cycle it was sampled
    property p_go_busy;
        psel && penable && !q.pready && paddr == `OFF_STAT
            |=> prdata[`STAT_BUSY] == ($past(q.go) != GO_IDLE);
    endproperty
    a_go_busy: assert property (p_go_busy)
        else $error("busy bit read back wrong");
    property p_go_start;
        go_req && q.go == GO_IDLE |=> q.go != GO_IDLE;
    endproperty
    a_go_start: assert property (p_go_start)
        else $error("trigger did not start apply");
    property p_pause_low;
        q.go == GO_PAUSE |=> ((system_clock & ~$past(system_clock) & $past(q.hold)) == '0)
            || $past(src_tick);
    endproperty
    a_pause_low: assert property (p_pause_low)
        else $error("held clock rose outside the restart tick");
    property p_unaligned_now;
        go_req && q.go == GO_IDLE && q.chg[0] && !q.align[0]
            |=> q.act_ratio[0] == $past(q.div_ratio[0]);
    endproperty
    a_unaligned_now: assert property (p_unaligned_now)
        else $error("unaligned clock did not switch at once");
    property p_flag_set;
        wr && paddr == div_addr(0) && pwdata[4:0] != q.div_ratio[0] |=> q.chg[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("change flag not set");
    // Lock may stand only if the reset bit was released the cycle before
    property p_pll_reset;
        wr && paddr == `OFF_CTL |=> q.ctl_rst == $past(pwdata[`CTL_RST])
            ##1 !($past(q.ctl_rst) && q.locked);
    endproperty
    a_pll_reset: assert property (p_pll_reset)
        else $error("PLL reset bit not applied");
    property p_flags_clear;
        q.go == GO_DONE |=> (q.chg & $past(q.op_mask) & ~$past(set_chg)) == '0;
    endproperty
    a_flags_clear: assert property (p_flags_clear)
        else $error("change flags left after apply");
    c_aligned_apply: cover property (q.go == GO_PAUSE ##[1:1000] q.go == GO_DONE);
    c_pll_locked: cover property (pll_mode && q.locked && src_tick);
    c_slverr: cover property (pslverr);

endmodule // pll_clock_divider_controller

// ### verification/test_pll_clock_divider_controller.sv
// Self-checking bench for the PLL clock controller: APB register tests and clock timing.
// Assumes the design config header is on the include path and clk_sys runs at 100 MHz.
`include "pll_clk_cfg.svh"

module test_pll_clock_divider_controller;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 64;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic aux_ref_clock;
    logic [15:0] system_clock;
    logic mon;
    int msel = 16;
    int error_cnt = 0;
    int cmp_count = 0;
    int diff;

    ////////////////////////////////////////////////////////////////////////////
    // Short lock count keeps the run brief; REF_HALF stays 64 so x64 fits
    pll_clock_divider_controller #(.NUM_DIV(16), .REF_HALF(HALF), .LOCK_CYC(4)) dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aux_ref_clock(aux_ref_clock), .system_clock(system_clock));

    // Clock and monitored output select
    always #5 clk_sys = ~clk_sys;
    always_comb mon = (msel == 16) ? aux_ref_clock : system_clock[msel[3:0]];

    ////////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer; pready is looked at mid-cycle, where it has settled,
    // and the request stays up through the rising edge that samples it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(negedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) error_cnt++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, eerr});
    endtask

    // Polls busy with a bound, since a hung apply must not stall the run
    task automatic wait_idle();
        logic [31:0] q;
        logic e;
        int n = 0;
        do begin
            apb(1'b0, `OFF_STAT, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        check(32'(n < 100), 32'h1);
    endtask

    // Cycles between two toggles of the selected clock
    task automatic chk_half(input int sel, input int exp);
        logic last;
        int n = 0;
        int hp = 0;
        msel = sel;
        @(negedge clk_sys);
        last = mon;
        while (mon === last && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        last = mon;
        while (mon === last && hp < 1000) begin
            @(negedge clk_sys);
            hp++;
        end
        check(32'(hp), 32'(exp));
    endtask

    // Selected clock must never move; with low set it must also sit at 0.
    // A starved divider freezes at whatever level it had, so low is not forced.
    task automatic chk_still(input int sel, input logic low);
        logic lvl;
        int t = 0;
        msel = sel;
        @(negedge clk_sys);
        lvl = low ? 1'b0 : mon;
        repeat (300) begin
            @(negedge clk_sys);
            if (mon !== lvl) t++;
        end
        check(32'(t), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: whole sequence needs well under 10k cycles
    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`OFF_CTL, 32'h68, 1'b0);
        rd_chk(`OFF_DIV1, 32'h8000, 1'b0);
        rd_chk(`OFF_STAT, 32'h0, 1'b0);
        rd_chk(`OFF_CHG, 32'h0, 1'b0);
        rd_chk(12'h104, 32'h0, 1'b1);
        wr(12'h104, 32'hffff);
        rd_chk(`OFF_CMD, 32'h0, 1'b0);
        chk_half(16, HALF);
        chk_half(0, HALF);
        wr(`OFF_MULT, 32'h3f);
        rd_chk(`OFF_MULT, 32'h3f, 1'b0);
        wr(`OFF_PRE, 32'h801f);
        rd_chk(`OFF_PRE, 32'h801f, 1'b0);
        $display("test reset done");
        // Unaligned ratio change
        wr(`OFF_DIV1, 32'h8001);
        rd_chk(`OFF_CHG, 32'h1, 1'b0);
        chk_half(0, HALF);
        wr(`OFF_ALIGN, 32'h0);
        wr(`OFF_CMD, 32'h1);
        wait_idle();
        rd_chk(`OFF_CHG, 32'h0, 1'b0);
        chk_half(0, 2 * HALF);
        chk_half(1, HALF);
        wr(12'h11c, 32'h0);
        chk_still(1, 1'b1);
        $display("test unaligned done");
        // Aligned ratio change of dividers 3 and 4
        wr(12'h120, 32'h8002);
        wr(`OFF_DIV4, 32'h8002);
        wr(`OFF_ALIGN, 32'hc);
        rd_chk(`OFF_CHG, 32'hc, 1'b0);
        @(posedge aux_ref_clock);
        wr(`OFF_CMD, 32'h1);
        rd_chk(`OFF_STAT, 32'h1, 1'b0);
        wait_idle();
        diff = 0;
        repeat (400) begin
            @(negedge clk_sys);
            if (system_clock[2] !== system_clock[3]) diff++;
        end
        check(32'(diff), 32'h0);
        chk_half(2, 3 * HALF);
        rd_chk(`OFF_CHG, 32'h0, 1'b0);
        $display("test aligned done");
        // Mode select ignored while source bit is 1, then PLL mode x2
        wr(`OFF_CTL, 32'h29);
        chk_half(4, HALF);
        wr(`OFF_CTL, 32'h08);
        // Four periods of the slower clock before touching the PLL settings
        repeat (8 * HALF) @(posedge clk_sys);
        wr(`OFF_PRE, 32'h8000);
        wr(`OFF_MULT, 32'h1);
        wr(`OFF_CTL, 32'h00);
        repeat (10) @(posedge clk_sys);
        rd_chk(`OFF_STAT, 32'h2, 1'b0);
        wr(`OFF_CTL, 32'h01);
        rd_chk(`OFF_CTL, 32'h41, 1'b0);
        chk_half(4, HALF / 2);
        chk_half(0, HALF);
        wr(`OFF_PRE, 32'h8001);
        chk_half(4, HALF);
        wr(`OFF_PRE, 32'h0001);
        chk_still(4, 1'b0);
        wr(`OFF_PRE, 32'h8000);
        wr(`OFF_CTL, 32'h09);
        rd_chk(`OFF_STAT, 32'h0, 1'b0);
        chk_still(4, 1'b0);
        $display("test mode done");
        report_and_stop();
    end
endmodule // test_pll_clock_divider_controller
